// ### pcb_defines.svh
/*
  constants for the bridge identifier and command register block:
  dword offsets, command bit positions, widths and reset values.
  assumes it is included by bare name from the command register block and the bench.
*/
`ifndef PCB_DEFINES_SVH
`define PCB_DEFINES_SVH

// configuration dword byte offsets
`define PCB_OFF_IDENT 12'h000
`define PCB_OFF_CMD 12'h004
`define PCB_ADDR_W 12

// identifier field layout in the first dword
`define PCB_MAKER_LSB 0
`define PCB_PART_LSB 16
`define PCB_ID_W 16

// command bit positions
`define PCB_CMD_IO 0
`define PCB_CMD_MEM 1
`define PCB_CMD_BM 2
`define PCB_CMD_PER 6
`define PCB_CMD_SERR 8
`define PCB_CMD_INTD 10
`define PCB_CMD_W 16

// writable command bits, all others read zero
`define PCB_CMD_WMASK 16'h0547
`define PCB_CMD_RESET 16'h0000

// default identifiers (arbitrary neutral values)
`define PCB_MAKER_DEF 16'h1234
`define PCB_PART_DEF 16'h5678

`endif

// ### pcb_pkg.sv
/*
  types for the bridge identifier and command register block.
  assumes nothing of its surroundings.
*/
package pcb_pkg;
  // which register a configuration access hits
  typedef enum logic [1:0] {
    PCB_SEL_NONE = 2'b00,
    PCB_SEL_IDENT = 2'b01,
    PCB_SEL_CMD = 2'b10
  } pcb_sel_t;
endpackage

// ### pcb_id_hold.sv
/*
  holds one read-only 16-bit identifier. an override path (smbus or
  eeprom loader, outside this block) may replace the default; the
  configuration side can never write it.
  assumes load comes from logic on the same clock.
*/
module pcb_id_hold #(
  parameter logic [15:0] DEFAULT = 16'h0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [15:0] load_val,
  output logic [15:0] value
);
  logic [15:0] next_value; // value after this cycle

  // only the override path changes the identifier
  always_comb
  begin
    next_value = value;
    if (load)
    begin
      next_value = load_val;
    end
  end

  // register with reset to the default
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      value <= DEFAULT;
    end
    else
    begin
      value <= next_value;
    end
  end
endmodule

// ### pcb_cmd_regs.sv
/*
  identifier and command registers at the start of a bridge type-1
  configuration header, with the gates the command bits drive.
  assumes configuration requests come from logic on clk, one per cycle,
  and that the identifier loader sits on the same clock.
*/
`include "pcb_defines.svh"
module pcb_cmd_regs #(
  parameter logic [15:0] MAKER_DEF = `PCB_MAKER_DEF, // arbitrary value
  parameter logic [15:0] PART_DEF = `PCB_PART_DEF // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  // configuration request from the upstream port
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // identifier override path
  input wire logic id_load,
  input wire logic [15:0] maker_load,
  input wire logic [15:0] part_load,
  // primary side requests
  input wire logic pri_io_req,
  input wire logic pri_mem_req,
  output logic pri_io_accept,
  output logic pri_mem_accept,
  // downstream-originated memory/io requests
  input wire logic dn_req,
  input wire logic dn_nonposted,
  output logic up_fwd,
  output logic dn_ur,
  output logic dn_ur_cpl,
  // error events
  input wire logic parity_err,
  input wire logic fatal_err,
  input wire logic nonfatal_err,
  output logic parity_act,
  output logic err_fatal_msg,
  output logic err_nonfatal_msg,
  // interrupt messages
  input wire logic own_intx,
  input wire logic dn_intx,
  output logic intx_msg,
  // command state for the rest of the bridge
  output logic [15:0] command_control
);
  logic [15:0] maker_identifier; // live maker id
  logic [15:0] part_identifier; // live part id
  pcb_pkg::pcb_sel_t sel; // decoded register
  logic [15:0] next_cmd; // command after this cycle
  logic [31:0] next_rdata; // read data to register
  logic next_pri_io, next_pri_mem, next_up, next_ur, next_urc;
  logic next_par, next_fat, next_nf, next_intx;
  // offsets and write mask held at their own widths, so every slice
  // taken from them is exact and no compare or mask silently resizes
  localparam logic [11:0] OFF_IDENT = `PCB_OFF_IDENT; // ident dword
  localparam logic [11:0] OFF_CMD = `PCB_OFF_CMD; // command dword
  localparam logic [15:0] WMASK = `PCB_CMD_WMASK; // writable bits

  // identifiers cannot be touched from the config side
  pcb_id_hold #(.DEFAULT(MAKER_DEF)) u_maker (
    .clk(clk),
    .rst(rst),
    .load(id_load),
    .load_val(maker_load),
    .value(maker_identifier)
  );
  pcb_id_hold #(.DEFAULT(PART_DEF)) u_part (
    .clk(clk),
    .rst(rst),
    .load(id_load),
    .load_val(part_load),
    .value(part_identifier)
  );

  // address decode, dword aligned
  always_comb
  begin
    if (cfg_addr[11:2] == OFF_IDENT[11:2])
    begin
      sel = pcb_pkg::PCB_SEL_IDENT;
    end
    else if (cfg_addr[11:2] == OFF_CMD[11:2])
    begin
      sel = pcb_pkg::PCB_SEL_CMD;
    end
    else
    begin
      sel = pcb_pkg::PCB_SEL_NONE;
    end
  end

  // register writes and read mux; unmapped reads give zero
  always_comb
  begin
    next_cmd = command_control;
    next_rdata = 32'h0000_0000;
    if (cfg_req && cfg_wr && sel == pcb_pkg::PCB_SEL_CMD)
    begin
      // only enabled bytes and writable bits change
      if (cfg_be[0])
      begin
        next_cmd[7:0] = cfg_wdata[7:0] & WMASK[7:0];
      end
      if (cfg_be[1])
      begin
        next_cmd[15:8] = cfg_wdata[15:8] & WMASK[15:8];
      end
    end
    if (cfg_req && !cfg_wr)
    begin
      unique case (sel)
        pcb_pkg::PCB_SEL_IDENT:
          next_rdata = {part_identifier, maker_identifier};
        pcb_pkg::PCB_SEL_CMD:
          next_rdata = {16'h0000, command_control};
        pcb_pkg::PCB_SEL_NONE:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // gates driven by the command bits; outputs are registered so
  // every gate lags its request by exactly one cycle
  always_comb
  begin
    next_pri_io = pri_io_req && command_control[`PCB_CMD_IO];
    next_pri_mem = pri_mem_req && command_control[`PCB_CMD_MEM];
    next_up = dn_req && command_control[`PCB_CMD_BM];
    next_ur = dn_req && !command_control[`PCB_CMD_BM];
    next_urc = next_ur && dn_nonposted;
    next_par = parity_err && command_control[`PCB_CMD_PER];
    next_fat = fatal_err && command_control[`PCB_CMD_SERR];
    next_nf = nonfatal_err && command_control[`PCB_CMD_SERR];
    // downstream intx passes regardless of the disable bit
    next_intx = dn_intx ||
      (own_intx && !command_control[`PCB_CMD_INTD]);
  end

  // state and output registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      command_control <= `PCB_CMD_RESET;
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
      pri_io_accept <= 1'b0;
      pri_mem_accept <= 1'b0;
      up_fwd <= 1'b0;
      dn_ur <= 1'b0;
      dn_ur_cpl <= 1'b0;
      parity_act <= 1'b0;
      err_fatal_msg <= 1'b0;
      err_nonfatal_msg <= 1'b0;
      intx_msg <= 1'b0;
    end
    else
    begin
      command_control <= next_cmd;
      cfg_ack <= cfg_req;
      cfg_rdata <= next_rdata;
      pri_io_accept <= next_pri_io;
      pri_mem_accept <= next_pri_mem;
      up_fwd <= next_up;
      dn_ur <= next_ur;
      dn_ur_cpl <= next_urc;
      parity_act <= next_par;
      err_fatal_msg <= next_fat;
      err_nonfatal_msg <= next_nf;
      intx_msg <= next_intx;
    end
  end

  // checks
  ro_bits_zero_a: assert property (@(posedge clk) disable iff (rst)
    (command_control & ~WMASK) == 16'h0000)
    else $error("read-only command bits not zero");
  io_gate_a: assert property (@(posedge clk) disable iff (rst)
    pri_io_accept |-> $past(command_control[`PCB_CMD_IO]))
    else $error("io accepted while disabled");
  mem_gate_a: assert property (@(posedge clk) disable iff (rst)
    pri_mem_req && command_control[`PCB_CMD_MEM] |=> pri_mem_accept)
    else $error("memory request not accepted");
  ur_path_a: assert property (@(posedge clk) disable iff (rst)
    dn_req && !command_control[`PCB_CMD_BM] |=> dn_ur && !up_fwd)
    else $error("downstream request not refused");
  // a non-posted refusal must also raise the completion strobe
  urc_path_a: assert property (@(posedge clk) disable iff (rst)
    dn_req && dn_nonposted && !command_control[`PCB_CMD_BM] |=> dn_ur_cpl)
    else $error("refused non-posted request without completion");
  fwd_path_a: assert property (@(posedge clk) disable iff (rst)
    dn_req && command_control[`PCB_CMD_BM] |=> up_fwd && !dn_ur)
    else $error("downstream request not forwarded");
  parity_gate_a: assert property (@(posedge clk) disable iff (rst)
    parity_act |-> $past(command_control[`PCB_CMD_PER]))
    else $error("parity action while disabled");
  err_gate_a: assert property (@(posedge clk) disable iff (rst)
    err_fatal_msg || err_nonfatal_msg |->
    $past(command_control[`PCB_CMD_SERR]))
    else $error("error reported while disabled");
  intx_pass_a: assert property (@(posedge clk) disable iff (rst)
    dn_intx |=> intx_msg)
    else $error("downstream intx blocked");
  // the disable bit must really silence our own interrupt
  intx_block_a: assert property (@(posedge clk) disable iff (rst)
    own_intx && !dn_intx && command_control[`PCB_CMD_INTD] |=> !intx_msg)
    else $error("own intx sent while disabled");
  ident_read_a: assert property (@(posedge clk) disable iff (rst)
    cfg_req && !cfg_wr && cfg_addr[11:2] == OFF_IDENT[11:2] && !id_load |=>
    cfg_rdata == {part_identifier, maker_identifier})
    else $error("identifier read wrong");
  be_hold_a: assert property (@(posedge clk) disable iff (rst)
    cfg_req && cfg_wr && !cfg_be[1] |=>
    command_control[15:8] == $past(command_control[15:8]))
    else $error("unenabled byte changed");
endmodule

// ### pcb_rc_model.sv
/*
  root complex model: issues configuration reads and writes.
  assumes the bridge acks each request one clk later.
*/
module pcb_rc_model (
  input wire logic clk,
  output logic cfg_req,
  output logic cfg_wr,
  output logic [11:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle lines from time zero
  initial
  begin
    cfg_req = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 12'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  // one access, answer taken at the edge that shows the ack
  task automatic access(input logic wr, input logic [11:0] a,
    input logic [3:0] be, input logic [31:0] wd,
    output logic [31:0] rd, output logic ok);
    @(posedge clk);
    cfg_req <= 1'b1;
    cfg_wr <= wr;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= wd;
    @(posedge clk);
    cfg_req <= 1'b0;
    cfg_wdata <= ~wd; // released data must not look still valid
    // the ack is due exactly one edge after the take, never later
    @(posedge clk);
    ok = (cfg_ack === 1'b1);
    rd = cfg_rdata;
  endtask
endmodule

// ### pcb_cmd_regs_tb.sv
/*
  self-checking bench for the identifier and command registers.
  assumes the root complex model drives the configuration port.
*/
`include "pcb_defines.svh"
module pcb_cmd_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MK = 16'h1a2b; // arbitrary value
  localparam logic [15:0] PT = 16'h3c4d; // arbitrary value
  localparam logic [15:0] CS [8] = '{16'h0000, 16'h0001, 16'h0002,
    16'h0004, 16'h0040, 16'h0100, 16'h0400, 16'hffff};
  logic clk, rst, cfg_req, cfg_wr, cfg_ack, id_load, ok;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [15:0] maker_load, part_load, command_control;
  logic [8:0] req; // io mem dn np par fat nf own dnintx
  logic [8:0] rsp; // io mem fwd ur urcpl par fat nf intx
  int n_errors, n_tests, cyc;
  pcb_rc_model rc_u (.clk(clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
  pcb_cmd_regs #(.MAKER_DEF(MK), .PART_DEF(PT)) dut_u (.clk(clk),
    .rst(rst), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .id_load(id_load), .maker_load(maker_load),
    .part_load(part_load), .pri_io_req(req[8]), .pri_mem_req(req[7]),
    .pri_io_accept(rsp[8]), .pri_mem_accept(rsp[7]), .dn_req(req[6]),
    .dn_nonposted(req[5]), .up_fwd(rsp[6]), .dn_ur(rsp[5]),
    .dn_ur_cpl(rsp[4]), .parity_err(req[4]), .fatal_err(req[3]),
    .nonfatal_err(req[2]), .parity_act(rsp[3]), .err_fatal_msg(rsp[2]),
    .err_nonfatal_msg(rsp[1]), .own_intx(req[1]), .dn_intx(req[0]),
    .intx_msg(rsp[0]), .command_control(command_control));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cut a hang short; the whole run needs under two hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      results();
    end
  end
  // shared compare
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one access, its ack is checked every time
  task automatic rw(input logic wr, input logic [11:0] a,
    input logic [3:0] be, input logic [31:0] wd);
    rc_u.access(wr, a, be, wd, rd, ok);
    chk("cfg_ack", 32'h1, {31'h0, ok});
  endtask
  // write command, read it back; status half is outside this block
  task automatic setc(input logic [15:0] c, input logic [3:0] be);
    rw(1'b1, `PCB_OFF_CMD, be, {16'hffff, c});
    rw(1'b0, `PCB_OFF_CMD, 4'hf, 32'h0);
  endtask
  // pulse request inputs, expect gated results one cycle later
  task automatic gate(input logic [8:0] r, input logic [15:0] c);
    logic [8:0] e;
    e = {r[8] & c[0], r[7] & c[1], r[6] & c[2], r[6] & !c[2],
      r[6] & r[5] & !c[2], r[4] & c[6], r[3] & c[8], r[2] & c[8],
      r[0] | (r[1] & !c[10])};
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req <= 9'h000;
    #1;
    chk("gates", {23'h0, e}, {23'h0, rsp});
  endtask
  // main sequence
  initial
  begin
    rst = 1'b1;
    req = 9'h000;
    id_load = 1'b0;
    maker_load = 16'h0000;
    part_load = 16'h0000;
    repeat (20) @(posedge clk);
    chk("cmd reset", 32'h0, {16'h0, command_control});
    rst <= 1'b0;
    rw(1'b0, `PCB_OFF_IDENT, 4'hf, 32'h0);
    chk("ident", {PT, MK}, rd);
    rw(1'b1, `PCB_OFF_IDENT, 4'hf, 32'hffffffff);
    rw(1'b0, `PCB_OFF_IDENT, 4'hf, 32'h0);
    chk("ident kept", {PT, MK}, rd);
    rw(1'b0, 12'h0f0, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 8; i++)
    begin
      setc(CS[i], 4'h3);
      chk("cmd", {16'h0, CS[i] & 16'h0547}, {16'h0, rd[15:0]});
      chk("cmd out", {16'h0, CS[i] & 16'h0547},
        {16'h0, command_control});
      gate(9'h1ff, CS[i]);
      gate(9'h1de, CS[i]);
      gate(9'h021, CS[i]);
    end
    setc(16'h0000, 4'h2); // low byte kept
    chk("be low", 32'h0047, {16'h0, rd[15:0]});
    setc(16'hff00, 4'h1); // high byte kept
    chk("be high", 32'h0000, {16'h0, rd[15:0]});
    @(posedge clk);
    id_load <= 1'b1;
    maker_load <= 16'h0f0e;
    part_load <= 16'h0d0c;
    @(posedge clk);
    id_load <= 1'b0;
    rw(1'b0, `PCB_OFF_IDENT, 4'hf, 32'h0);
    chk("ident load", 32'h0d0c0f0e, rd);
    setc(16'h0547, 4'h3);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("cmd rereset", 32'h0, {16'h0, command_control});
    rw(1'b0, `PCB_OFF_IDENT, 4'hf, 32'h0);
    chk("ident rereset", {PT, MK}, rd);
    results();
  end
  // verdict and end of run
  task automatic results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
endmodule
